// *** core/ccwr_regs.svh ***
// constants of the codec control-word decoder: word fields, register
// offsets, bit positions and reset values.
// assumes inclusion by bare name from the package and the design modules.
`ifndef CCWR_REGS_SVH
`define CCWR_REGS_SVH

`define CCWR_WORD_W 16
`define CCWR_DEV_HI 15
`define CCWR_DEV_LO 13
`define CCWR_RW_BIT 12
`define CCWR_REG_HI 11
`define CCWR_REG_LO 9
`define CCWR_DATA_HI 7
`define CCWR_DATA_LO 0

`define CCWR_REG_NOP 3'h0
`define CCWR_REG_CTRL1 3'h1
`define CCWR_REG_CTRL2 3'h2
`define CCWR_REG_CTRL3 3'h3
`define CCWR_REG_CTRL4 3'h4

`define CCWR_CTRL1_RESET 8'h00
`define CCWR_CTRL2_RESET 8'h00

`define CCWR_C1_OVF 7
`define CCWR_C1_RX_AMP 6
`define CCWR_C1_AAF_BYP 5
`define CCWR_C1_AUX_SEL 4
`define CCWR_C1_SW_RST 3
`define CCWR_C1_FIR_BYP 2
`define CCWR_C1_TX_AMP 1
`define CCWR_C1_DAC16 0

`define CCWR_C2_LOW_PWR 7
`define CCWR_C2_DIV_HI 4
`define CCWR_C2_DIV_LO 0
`define CCWR_DIV_ZERO_N 6'h20

`define CCWR_SW_RST_CYCLES 4'h4

`endif

// *** core/ccwr_pkg.sv ***
// types of the codec control-word decoder.
// assumes ccwr_regs.svh is on the include path.
`include "ccwr_regs.svh"

package ccwr_pkg;

  typedef struct packed {
    logic [2:0] dev_addr;
    logic read;
    logic [2:0] reg_addr;
    logic unused;
    logic [7:0] data;
  } ccwr_word_t;

  typedef struct packed {
    logic receive_amp_en;
    logic aux_sel;
    logic aaf_bypass;
    logic fir_bypass;
    logic transmit_amp_en;
    logic dac_16bit;
    logic low_power;
    logic [5:0] divider_n;
  } ccwr_ctrl_t;

  typedef enum logic [1:0] {
    CCWR_IDLE,
    CCWR_SHIFT,
    CCWR_DONE
  } ccwr_state_t;

endpackage

// *** core/ccwr_sync.sv ***
// two-flop synchroniser for a level.
// assumes the input comes from another clock domain or a pin.
`timescale 1ns/1ps
`default_nettype none

module ccwr_sync (
  input wire logic clk, // destination clock
  input wire logic rst, // synchronous reset, active high
  input wire logic d, // asynchronous level
  output logic q // synchronised level
);
  logic meta_reg, meta_next, q_reg, q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

`default_nettype wire

// *** core/ccwr_link.sv ***
// serial link side: shifts a 16-bit control word in on din while the
// frame is low and shifts the 16-bit response out on dout.
// assumes sclk is the link clock, frame_n low for exactly 16 edges.
`timescale 1ns/1ps
`default_nettype none

module ccwr_link
  import ccwr_pkg::*;
(
  input wire logic sclk, // link clock
  input wire logic frame_n, // frame, active low
  input wire logic din, // serial data in, msb first
  input wire logic [15:0] resp, // response word, stable in frame
  output logic dout, // serial data out
  output logic dout_oe_n, // dout enable, low while driving
  output logic [15:0] word, // last whole word
  output logic word_tgl // high for one link clock after a whole word
);
  logic [15:0] sh_reg, sh_next, word_reg, word_next, out_reg, out_next;
  logic [4:0] cnt_reg, cnt_next;
  logic tgl_reg, tgl_next;

  always_comb begin
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    word_next = word_reg;
    tgl_next = 1'b0;
    out_next = out_reg;
    if (!frame_n) begin
      sh_next = {sh_reg[14:0], din};
      // bit 15 goes out on the first rise so the host reads it after it
      out_next = (cnt_reg == 5'h00) ? resp : {out_reg[14:0], 1'b0};
      cnt_next = cnt_reg + 5'h01;
      if (cnt_reg == 5'h0f) begin
        word_next = {sh_reg[14:0], din};
        tgl_next = 1'b1;
        cnt_next = 5'h00;
      end
    end else begin
      cnt_next = 5'h00;
      out_next = resp;
    end
  end

  always_ff @(posedge sclk) begin
    sh_reg <= sh_next;
    cnt_reg <= cnt_next;
    word_reg <= word_next;
    tgl_reg <= tgl_next;
    out_reg <= out_next;
  end

  assign dout = out_reg[15];
  assign dout_oe_n = frame_n;
  assign word = word_reg;
  assign word_tgl = tgl_reg;
endmodule

`default_nettype wire

// *** core/ccwr_core.sv ***
// codec control-word decoder and control registers one and two.
// assumes a host shifting 16-bit words on its own serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "ccwr_regs.svh"

module ccwr_core
  import ccwr_pkg::*;
(
  input wire logic CLOCK, // core clock, 250 MHz
  input wire logic RESET, // synchronous reset, active high
  input wire logic SCLK, // serial link clock
  input wire logic FRAME_N, // frame sync, active low
  input wire logic DIN, // serial control word in
  output logic DOUT, // serial response out
  output logic DOUT_OE_N, // dout enable, low while driving
  input wire logic CASCADED, // pin: part of a cascade
  input wire logic [2:0] CHAIN_POS, // pin: position from cascade detect
  input wire logic OVERFLOW, // pin: decimation filter overflow
  output logic RECEIVE_AMP_EN, // receive amplifier on
  output logic AUX_SEL, // aux_input_pos/neg to adc, else main
  output logic AAF_BYPASS, // antialias filter bypassed
  output logic FIR_BYPASS, // fir filters bypassed
  output logic TRANSMIT_AMP_EN, // transmit_amp_a and _b on
  output logic DAC_16BIT, // 16-bit dac data format
  output logic LOW_POWER, // low-power operation
  output logic [5:0] DIVIDER_N, // divider n, 1 to 32
  output logic SOFT_RESET, // one-shot software reset
  output logic [2:0] OWN_ADDR // own cascade address
);
  ccwr_word_t word_in;
  ccwr_ctrl_t ctrl;
  logic [15:0] link_word;
  logic link_tgl, tgl_s, cascaded_s, ovf_s;
  logic [2:0] pos_s;
  logic tgl_seen_reg, tgl_seen_next;
  logic [7:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next;
  logic [2:0] addr_reg, addr_next;
  logic [15:0] resp_reg, resp_next;
  logic [3:0] rst_cnt_reg, rst_cnt_next;

  ccwr_link u_link (
    .sclk(SCLK),
    .frame_n(FRAME_N),
    .din(DIN),
    .resp(resp_reg),
    .dout(DOUT),
    .dout_oe_n(DOUT_OE_N),
    .word(link_word),
    .word_tgl(link_tgl)
  );

  ccwr_sync u_tgl (.clk(CLOCK), .rst(RESET), .d(link_tgl), .q(tgl_s));
  ccwr_sync u_casc (.clk(CLOCK), .rst(RESET), .d(CASCADED), .q(cascaded_s));
  ccwr_sync u_ovf (.clk(CLOCK), .rst(RESET), .d(OVERFLOW), .q(ovf_s));

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pos
      ccwr_sync u_pos (.clk(CLOCK), .rst(RESET), .d(CHAIN_POS[g]),
        .q(pos_s[g]));
    end
  endgenerate

  // the link holds a whole word for a full frame after its pulse, so the
  // word is only read in the cycle the synchronised pulse is first seen
  assign word_in = ccwr_word_t'(link_word);

  function automatic logic [7:0] reg_read(input logic [2:0] a,
    input logic [7:0] c1, input logic [7:0] c2);
    case (a)
      `CCWR_REG_CTRL1: reg_read = c1;
      `CCWR_REG_CTRL2: reg_read = c2;
      default: reg_read = 8'h00;
    endcase
  endfunction

  always_comb begin
    tgl_seen_next = tgl_s;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    resp_next = resp_reg;
    rst_cnt_next = (rst_cnt_reg != 4'h0) ? rst_cnt_reg - 4'h1 : 4'h0;
    // a standalone part is zero, a chained part takes its position
    addr_next = cascaded_s ? pos_s : 3'h0;
    ctrl1_next[`CCWR_C1_OVF] = ovf_s;
    ctrl1_next[`CCWR_C1_SW_RST] = 1'b0;
    if ((tgl_s && !tgl_seen_reg) &&
        (word_in.dev_addr == addr_reg)) begin
      if (!word_in.read) begin
        unique case (word_in.reg_addr)
          `CCWR_REG_CTRL1: begin
            ctrl1_next[6:0] = word_in.data[6:0];
            ctrl1_next[`CCWR_C1_SW_RST] = 1'b0;
            if (word_in.data[`CCWR_C1_SW_RST]) begin
              rst_cnt_next = `CCWR_SW_RST_CYCLES;
            end
          end
          `CCWR_REG_CTRL2: begin
            ctrl2_next = word_in.data;
          end
          default: begin
          end
        endcase
        resp_next = {word_in.dev_addr, word_in.read, word_in.reg_addr,
          1'b0, reg_read(word_in.reg_addr, ctrl1_reg, ctrl2_reg)};
      end else begin
        resp_next = {word_in.dev_addr, word_in.read, word_in.reg_addr,
          1'b0, reg_read(word_in.reg_addr, ctrl1_reg, ctrl2_reg)};
      end
    end
    if (rst_cnt_reg != 4'h0) begin
      // software reset returns the writable fields to defaults
      ctrl1_next = `CCWR_CTRL1_RESET;
      ctrl2_next = `CCWR_CTRL2_RESET;
      ctrl1_next[`CCWR_C1_OVF] = ovf_s;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      tgl_seen_reg <= 1'b0;
      ctrl1_reg <= `CCWR_CTRL1_RESET;
      ctrl2_reg <= `CCWR_CTRL2_RESET;
      addr_reg <= 3'h0;
      resp_reg <= 16'h0000;
      rst_cnt_reg <= 4'h0;
    end else begin
      tgl_seen_reg <= tgl_seen_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      addr_reg <= addr_next;
      resp_reg <= resp_next;
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  always_comb begin
    ctrl.receive_amp_en = ctrl1_reg[`CCWR_C1_RX_AMP];
    ctrl.aux_sel = ctrl1_reg[`CCWR_C1_AUX_SEL];
    ctrl.aaf_bypass = ctrl1_reg[`CCWR_C1_AAF_BYP];
    ctrl.fir_bypass = ctrl1_reg[`CCWR_C1_FIR_BYP];
    ctrl.transmit_amp_en = ctrl1_reg[`CCWR_C1_TX_AMP];
    ctrl.dac_16bit = ctrl1_reg[`CCWR_C1_DAC16];
    ctrl.low_power = ctrl2_reg[`CCWR_C2_LOW_PWR];
    ctrl.divider_n = (ctrl2_reg[4:0] == 5'h00) ? `CCWR_DIV_ZERO_N
      : {1'b0, ctrl2_reg[4:0]};
  end

  assign RECEIVE_AMP_EN = ctrl.receive_amp_en;
  assign AUX_SEL = ctrl.aux_sel;
  assign AAF_BYPASS = ctrl.aaf_bypass;
  assign FIR_BYPASS = ctrl.fir_bypass;
  assign TRANSMIT_AMP_EN = ctrl.transmit_amp_en;
  assign DAC_16BIT = ctrl.dac_16bit;
  assign LOW_POWER = ctrl.low_power;
  assign DIVIDER_N = ctrl.divider_n;
  assign SOFT_RESET = (rst_cnt_reg != 4'h0);
  assign OWN_ADDR = addr_reg;
endmodule

`default_nettype wire

// *** testbench/ccwr_core_assertions.sv ***
// checker of the control-word decoder, bound to ccwr_core.
// assumes one core clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ccwr_core_chk (
  input wire logic CLOCK, // core clock
  input wire logic RESET, // reset
  input wire logic FRAME_N, // frame
  input wire logic DOUT_OE_N, // dout enable
  input wire logic CASCADED, // cascade pin
  input wire logic [2:0] CHAIN_POS, // position pin
  input wire logic RECEIVE_AMP_EN, // ctrl1 bit 6
  input wire logic DAC_16BIT, // ctrl1 bit 0
  input wire logic LOW_POWER, // ctrl2 bit 7
  input wire logic [5:0] DIVIDER_N, // divider
  input wire logic SOFT_RESET, // one-shot reset
  input wire logic [2:0] OWN_ADDR // own address
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence pulse4;
    SOFT_RESET [*4] ##1 !SOFT_RESET;
  endsequence
  sequence quiet8;
    (FRAME_N && !SOFT_RESET) [*8];
  endsequence
  AST_RST_VAL: assert property (
    $fell(RESET) |-> !LOW_POWER && !RECEIVE_AMP_EN && DIVIDER_N == 6'h20)
    else $error("reset values wrong");
  AST_DIV_RANGE: assert property (
    DIVIDER_N inside {[6'h01:6'h20]}) else $error("divider out of range");
  AST_OWN_ALONE: assert property (
    !CASCADED [*5] |-> OWN_ADDR == 3'h0) else $error("alone not zero");
  AST_OWN_CASC: assert property (
    (CASCADED && $stable(CHAIN_POS)) [*5] |-> OWN_ADDR == CHAIN_POS)
    else $error("cascade address wrong");
  AST_SOFT_PULSE: assert property (
    $rose(SOFT_RESET) |-> pulse4) else $error("soft reset length");
  AST_SOFT_CLR: assert property (
    $fell(SOFT_RESET) |-> !RECEIVE_AMP_EN && !LOW_POWER
      && DIVIDER_N == 6'h20) else $error("soft reset left state");
  AST_OE: assert property (
    DOUT_OE_N == FRAME_N) else $error("dout enable wrong");
  AST_QUIET: assert property (
    quiet8 |=> SOFT_RESET
      || $stable({RECEIVE_AMP_EN, DAC_16BIT, LOW_POWER, DIVIDER_N}))
    else $error("control changed without a word");
endmodule
bind ccwr_core ccwr_core_chk chk (.CLOCK(CLOCK), .RESET(RESET),
  .FRAME_N(FRAME_N), .DOUT_OE_N(DOUT_OE_N), .CASCADED(CASCADED),
  .CHAIN_POS(CHAIN_POS), .RECEIVE_AMP_EN(RECEIVE_AMP_EN),
  .DAC_16BIT(DAC_16BIT), .LOW_POWER(LOW_POWER), .DIVIDER_N(DIVIDER_N),
  .SOFT_RESET(SOFT_RESET), .OWN_ADDR(OWN_ADDR));
`default_nettype wire

// *** testbench/ccwr_host.sv ***
// host serial port model: frames 16-bit words, collects responses.
// runs the link clock inside frames and for three periods after each, 64 ns period.
`timescale 1ns/1ps
`default_nettype none
module ccwr_host
  import ccwr_pkg::*;
(
  output logic sclk, // link clock
  output logic frame_n, // frame, active low
  output logic din, // data to codec
  input wire logic dout // data from codec
);
  initial begin
    sclk = 1'b0;
    frame_n = 1'b1;
    din = 1'b1;
  end
  task automatic xfer(input ccwr_word_t w, output logic [15:0] r);
    #1.3 frame_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din = w[i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
      r[i] = dout;
    end
    frame_n = 1'b1;
    din = ~din;
    repeat (3) begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #200;
  endtask
endmodule
`default_nettype wire

// *** testbench/ccwr_core_test.sv ***
// self-checking bench of the control-word decoder.
// assumes ccwr_host as the serial host and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module ccwr_core_test;
  import ccwr_pkg::*;
  logic clock, reset, cascaded, overflow, dout, dout_oe_n;
  logic sclk, frame_n, din, rx_amp, aux, aaf, fir, tx_amp, d16, lp, srst;
  logic [2:0] chain_pos, own;
  logic [5:0] div_n;
  logic [15:0] resp;
  int mismatches, comparisons, soft_cnt, cycles;
  wire logic [7:0] c1 = {1'b0, rx_amp, aaf, aux, 1'b0, fir, tx_amp, d16};
  ccwr_core dut (.CLOCK(clock), .RESET(reset), .SCLK(sclk),
    .FRAME_N(frame_n), .DIN(din), .DOUT(dout), .DOUT_OE_N(dout_oe_n),
    .CASCADED(cascaded), .CHAIN_POS(chain_pos), .OVERFLOW(overflow),
    .RECEIVE_AMP_EN(rx_amp), .AUX_SEL(aux), .AAF_BYPASS(aaf),
    .FIR_BYPASS(fir), .TRANSMIT_AMP_EN(tx_amp), .DAC_16BIT(d16),
    .LOW_POWER(lp), .DIVIDER_N(div_n), .SOFT_RESET(srst), .OWN_ADDR(own));
  ccwr_host host (.sclk(sclk), .frame_n(frame_n), .din(din), .dout(dout));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (srst === 1'b1)
      soft_cnt++;
    if (cycles == 40000) begin
      mismatches++;
      stop_test;
    end
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [2:0] dv, input logic r,
                      input logic [2:0] ra, input logic [7:0] d);
    @(posedge clock);
    host.xfer(ccwr_word_t'{dv, r, ra, 1'b0, d}, resp);
  endtask
  task automatic rd(input logic [2:0] dv, input logic [2:0] ra,
                    input logic [7:0] exp);
    send(dv, 1'b1, ra, 8'h00);
    send(dv, 1'b1, 3'h0, 8'h00);
    check(resp, {dv, 1'b1, ra, 1'b0, exp});
  endtask
  task automatic div_is(input logic l, input logic [5:0] n);
    check({9'h000, lp, div_n}, {9'h000, l, n});
  endtask
  task automatic t_reset;
    send(3'h0, 1'b1, 3'h0, 8'h00);
    check({4'h0, c1, lp, own}, 16'h0000);
    div_is(1'b0, 6'h20);
    rd(3'h0, 3'h1, 8'h00);
    rd(3'h0, 3'h2, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_ctrl;
    for (int i = 0; i < 7; i++) begin
      if (i != 3) begin
        send(3'h0, 1'b0, 3'h1, 8'h01 << i);
        check({8'h00, c1}, 16'h0001 << i);
      end
    end
    @(posedge clock) overflow <= 1'b1;
    rd(3'h0, 3'h1, 8'hc0);
    @(posedge clock) overflow <= 1'b0;
    send(3'h0, 1'b0, 3'h2, 8'h85);
    div_is(1'b1, 6'h05);
    send(3'h0, 1'b0, 3'h2, 8'h1f);
    div_is(1'b0, 6'h1f);
    send(3'h0, 1'b0, 3'h2, 8'h00);
    div_is(1'b0, 6'h20);
    $display("test control done");
  endtask
  task automatic t_refuse;
    send(3'h5, 1'b0, 3'h2, 8'h81);
    for (int r = 0; r < 5; r += 3)
      send(3'h0, 1'b0, 3'(r), 8'hff);
    send(3'h0, 1'b0, 3'h4, 8'hff);
    check({4'h0, c1, lp, own}, 16'h0400);
    div_is(1'b0, 6'h20);
    $display("test refuse done");
  endtask
  task automatic t_soft;
    send(3'h0, 1'b0, 3'h2, 8'h83);
    soft_cnt = 0;
    send(3'h0, 1'b0, 3'h1, 8'h4f);
    check(16'(soft_cnt), 16'h0004);
    check({4'h0, c1, lp, own}, 16'h0000);
    div_is(1'b0, 6'h20);
    rd(3'h0, 3'h1, 8'h00);
    $display("test soft reset done");
  endtask
  task automatic t_casc;
    @(posedge clock);
    cascaded <= 1'b1;
    chain_pos <= 3'h3;
    repeat (8) @(posedge clock);
    check({13'h0000, own}, 16'h0003);
    send(3'h3, 1'b0, 3'h2, 8'h03);
    div_is(1'b0, 6'h03);
    send(3'h0, 1'b0, 3'h2, 8'h07);
    div_is(1'b0, 6'h03);
    rd(3'h3, 3'h2, 8'h03);
    @(posedge clock) cascaded <= 1'b0;
    repeat (8) @(posedge clock);
    check({13'h0000, own}, 16'h0000);
    $display("test cascade done");
  endtask
  initial begin
    reset = 1'b1;
    cascaded = 1'b0;
    chain_pos = 3'h0;
    overflow = 1'b0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    t_reset;
    t_ctrl;
    t_refuse;
    t_soft;
    t_casc;
    stop_test;
  end
endmodule
`default_nettype wire
